// ### pkg/spi_master_map.svh
// Named constants of the serial master: mode code, tokens, widths and reset values
`ifndef SPI_MASTER_MAP_SVH
`define SPI_MASTER_MAP_SVH

`define SPI_MODE_W 2
`define SPI_MODE_SPI 2'h2
`define SPI_CHAR_W 8
`define SPI_EDGE_W 4
`define SPI_LAST_EDGE 4'hf
`define SPI_FIRST_EDGE 4'h0
`define SPI_FIFO_DEPTH 4
`define SPI_COUNT_W 3
`define SPI_BUSY_TOKEN 8'hff
`define SPI_EXTRA_TOKEN 8'hfe
`define SPI_RATE_W 4
`define SPI_DIV_W 20
`define SPI_EVT_W 9
`define SPI_STATUS_RESET 4'hc

`endif

// ### pkg/spi_master_pkg.sv
// Types shared by the serial master: configuration, status, events, DMA handshakes, state
`default_nettype none
package spi_master_pkg;
`include "spi_master_map.svh"

    typedef struct packed {
        logic [`SPI_MODE_W-1:0] controller_mode_field;
        logic spi_master_select;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic bit_order_bit;
        logic auto_tx_enable;
        logic repeat_on_underrun;
        logic [`SPI_RATE_W-1:0] rate_linear;
        logic [`SPI_RATE_W-1:0] rate_exponent;
    } spi_config_s;

    typedef struct packed {
        logic tx_idle_flag;
        logic tx_free_flag;
        logic rx_valid_flag;
        logic rx_overrun_flag;
    } spi_status_s;

    typedef struct packed {
        logic tx_underrun_irq;
        logic rx_overrun_irq;
        logic [1:0] rx_dma_done;
        logic [1:0] tx_dma_done;
        logic rx_valid;
        logic tx_free;
        logic tx_idle;
    } spi_event_s;

    typedef struct packed {
        logic [1:0] tx_dma_active;
        logic [1:0] rx_dma_active;
        logic rx_dma_reset;
        logic [1:0] rx_dma_load;
    } dma_in_s;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT} shift_state_e;

    typedef struct packed {
        shift_state_e st;
        logic miso_meta;
        logic miso_sync;
        logic [`SPI_CHAR_W-1:0] tx_sh;
        logic [`SPI_CHAR_W-1:0] rx_sh;
        logic [`SPI_CHAR_W-1:0] last_tx;
        logic [`SPI_EDGE_W-1:0] edge_cnt;
        logic from_fifo;
        logic pol_prev;
        logic extra_pending;
        logic sclk;
        logic sclk_oe;
        logic mosi;
        logic mosi_oe;
        spi_status_s status;
        spi_event_s ev;
        logic [`SPI_EVT_W-1:0] irq_flags;
        logic irq;
        logic ovf_pending;
        logic [1:0] dma_err;
        logic [3:0] dma_prev;
    } ctrl_state_s;

    function automatic logic [`SPI_CHAR_W-1:0] bit_reverse(input logic [`SPI_CHAR_W-1:0] d);
        logic [`SPI_CHAR_W-1:0] q;
        q = '0;
        for (int i = 0; i < `SPI_CHAR_W; i++) begin
            q[i] = d[`SPI_CHAR_W-1-i];
        end
        return q;
    endfunction : bit_reverse

endpackage : spi_master_pkg
`default_nettype wire

// ### design/spi_char_fifo.sv
// Small character FIFO with a registered read port
`timescale 1ns/1ps
`default_nettype none
module spi_char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_empty,
    output logic o_full,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
        logic [WIDTH-1:0] rd_data;
    } fifo_state_s;

    fifo_state_s r;
    fifo_state_s n;
    logic push_ok;
    logic pop_ok;

    assign push_ok = i_push && (r.count != (PTR_W+1)'(DEPTH));
    assign pop_ok = i_pop && (r.count != '0);

    // Popped data appears on the read port one cycle after the pop
    always_comb begin
        n = r;
        if (push_ok) begin
            n.mem[r.wr_ptr] = i_wr_data;
            n.wr_ptr = PTR_W'((r.wr_ptr + 1'b1) % DEPTH);
        end
        if (pop_ok) begin
            n.rd_data = r.mem[r.rd_ptr];
            n.rd_ptr = PTR_W'((r.rd_ptr + 1'b1) % DEPTH);
        end
        n.count = (PTR_W+1)'(r.count + push_ok - pop_ok);
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_rd_data = r.rd_data;
    assign o_empty = (r.count == '0);
    assign o_full = (r.count == (PTR_W+1)'(DEPTH));
    assign o_count = r.count;
endmodule : spi_char_fifo
`default_nettype wire

// ### design/spi_rate_gen.sv
// Half-bit tick generator: one tick every (linear+1)*2^exponent clocks
`timescale 1ns/1ps
`default_nettype none
module spi_rate_gen #(
    parameter int RATE_W = 4,
    parameter int DIV_W = 20
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_restart,
    input wire logic [RATE_W-1:0] i_linear,
    input wire logic [RATE_W-1:0] i_exponent,
    output logic o_tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } rate_state_s;

    rate_state_s r;
    rate_state_s n;
    logic [DIV_W-1:0] half;

    // Two half periods per bit give the full divide-by-2 of the bit rate
    assign half = (DIV_W'(i_linear) + DIV_W'(1)) << i_exponent;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (i_restart) begin
            n.cnt = '0;
        end else if (r.cnt >= half - DIV_W'(1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_tick = r.tick;
endmodule : spi_rate_gen
`default_nettype wire

// ### design/spi_master_fifo_controller.sv
// Serial master with transmit and receive character FIFOs, status flags and events
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_map.svh"
module spi_master_fifo_controller #(
    parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire spi_master_pkg::spi_config_s i_config,
    input wire logic i_tx_write,
    input wire logic [`SPI_CHAR_W-1:0] i_tx_data,
    input wire logic i_rx_read,
    input wire spi_master_pkg::dma_in_s i_dma,
    input wire logic [`SPI_EVT_W-1:0] i_irq_mask,
    input wire logic i_top_irq_mask,
    input wire logic [`SPI_EVT_W-1:0] i_irq_clear,
    input wire logic i_miso,
    output logic [`SPI_CHAR_W-1:0] o_rx_data,
    output spi_master_pkg::spi_status_s o_status,
    output spi_master_pkg::spi_event_s o_event,
    output logic [`SPI_EVT_W-1:0] o_irq_flags,
    output logic o_irq,
    output logic [1:0] o_rx_dma_error,
    output logic o_sclk,
    output logic o_sclk_oe,
    output logic o_mosi,
    output logic o_mosi_oe
);
    import spi_master_pkg::*;

    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

    localparam ctrl_state_s RESET_STATE = '{
        st: ST_IDLE,
        status: `SPI_STATUS_RESET,
        default: '0
    };

    ////////////////////////////////////////////////////////////////////////////
    // Signals

    ctrl_state_s r;
    ctrl_state_s n;

    logic enabled;
    logic tick;
    logic restart;
    logic tx_push;
    logic tx_pop;
    logic tx_empty;
    logic tx_full;
    logic tx_space;
    logic [CNT_W-1:0] tx_count;
    logic [`SPI_CHAR_W-1:0] tx_rd_data;
    logic rx_push;
    logic rx_empty;
    logic rx_full;
    logic [`SPI_CHAR_W-1:0] rx_char;
    logic leading;
    logic sample;
    logic drive;
    logic overrun_now;
    logic [`SPI_CHAR_W-1:0] rx_shift;

    ////////////////////////////////////////////////////////////////////////////
    // Character start: order the bits, preload the first bit when phase is 0

    function automatic ctrl_state_s begin_char(
        input ctrl_state_s s,
        input logic [`SPI_CHAR_W-1:0] c,
        input spi_config_s cfg
    );
        ctrl_state_s t;
        logic [`SPI_CHAR_W-1:0] ordered;
        t = s;
        ordered = cfg.bit_order_bit ? bit_reverse(c) : c;
        t.tx_sh = ordered;
        t.edge_cnt = `SPI_FIRST_EDGE;
        t.st = ST_SHIFT;
        if (!cfg.clock_phase_bit) begin
            t.mosi = ordered[`SPI_CHAR_W-1];
            t.tx_sh = ordered << 1;
        end
        return t;
    endfunction : begin_char

    ////////////////////////////////////////////////////////////////////////////
    // FIFOs and bit-rate generator

    spi_char_fifo #(
        .WIDTH(`SPI_CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_push(tx_push),
        .i_wr_data(i_tx_data),
        .i_pop(tx_pop),
        .o_rd_data(tx_rd_data),
        .o_empty(tx_empty),
        .o_full(tx_full),
        .o_count(tx_count)
    );

    spi_char_fifo #(
        .WIDTH(`SPI_CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_push(rx_push),
        .i_wr_data(rx_char),
        .i_pop(i_rx_read),
        .o_rd_data(o_rx_data),
        .o_empty(rx_empty),
        .o_full(rx_full),
        .o_count()
    );

    spi_rate_gen #(
        .RATE_W(`SPI_RATE_W),
        .DIV_W(`SPI_DIV_W)
    ) u_rate (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_restart(restart),
        .i_linear(i_config.rate_linear),
        .i_exponent(i_config.rate_exponent),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write side: a character in the serializer still owns a slot, so free
    // only returns once that character has been shifted out or dropped by an abort

    assign enabled = (i_config.controller_mode_field == `SPI_MODE_SPI)
        && i_config.spi_master_select;
    assign tx_space = (CNT_W+1)'(tx_count) + (CNT_W+1)'(r.from_fifo)
        < (CNT_W+1)'(FIFO_DEPTH);
    assign tx_push = i_tx_write && tx_space && !tx_full;

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine edge decode

    assign leading = !r.edge_cnt[0];
    assign sample = leading ^ i_config.clock_phase_bit;
    assign drive = i_config.clock_phase_bit ? leading
        : (!leading && r.edge_cnt != `SPI_LAST_EDGE);
    assign rx_shift = sample ? {r.rx_sh[`SPI_CHAR_W-2:0], r.miso_sync} : r.rx_sh;
    assign rx_char = i_config.bit_order_bit ? bit_reverse(rx_shift) : rx_shift;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n = r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        restart = 1'b0;
        overrun_now = 1'b0;
        n.ev = '0;

        // MISO is a pin: only the second flop is looked at
        n.miso_meta = i_miso;
        n.miso_sync = r.miso_meta;

        // Polarity falling without a mode reinit leaves a stray character queued
        n.pol_prev = i_config.clock_polarity_bit;
        if (i_config.controller_mode_field != `SPI_MODE_SPI) begin
            n.extra_pending = 1'b0;
        end else if (r.pol_prev && !i_config.clock_polarity_bit && r.sclk_oe) begin
            n.extra_pending = 1'b1;
        end

        n.sclk_oe = enabled;
        n.mosi_oe = enabled;

        case (r.st)
            ST_IDLE: begin
                n.sclk = i_config.clock_polarity_bit;
                if (enabled) begin
                    if (r.extra_pending && (!tx_empty || i_config.auto_tx_enable)) begin
                        n = begin_char(n, `SPI_EXTRA_TOKEN, i_config);
                        n.extra_pending = 1'b0;
                        restart = 1'b1;
                    end else if (!tx_empty) begin
                        tx_pop = 1'b1;
                        n.from_fifo = 1'b1;
                        n.st = ST_LOAD;
                    end else if (i_config.auto_tx_enable) begin
                        // Repeat mode is only ever changed while idle, so the
                        // choice here is stable for the whole character
                        n = begin_char(n, i_config.repeat_on_underrun ? r.last_tx
                            : `SPI_BUSY_TOKEN, i_config);
                        n.ev.tx_underrun_irq = 1'b1;
                        restart = 1'b1;
                    end
                    // With auto mode off and nothing queued no clocks run, so
                    // nothing more is received and the receive FIFO is kept
                end
            end
            ST_LOAD: begin
                n = begin_char(n, tx_rd_data, i_config);
                n.last_tx = tx_rd_data;
                restart = 1'b1;
            end
            ST_SHIFT: begin
                if (!enabled) begin
                    // Abort mid-character; the partial byte is discarded
                    n.st = ST_IDLE;
                    n.from_fifo = 1'b0;
                    n.sclk = i_config.clock_polarity_bit;
                end else if (tick) begin
                    n.sclk = !r.sclk;
                    n.edge_cnt = r.edge_cnt + 1'b1;
                    n.rx_sh = rx_shift;
                    if (drive) begin
                        n.mosi = r.tx_sh[`SPI_CHAR_W-1];
                        n.tx_sh = r.tx_sh << 1;
                    end
                    if (r.edge_cnt == `SPI_LAST_EDGE) begin
                        n.st = ST_IDLE;
                        n.from_fifo = 1'b0;
                        if (rx_full) begin
                            overrun_now = 1'b1;
                        end else begin
                            rx_push = 1'b1;
                        end
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // Status flags
        n.status.tx_idle_flag = tx_empty && !i_tx_write && (n.st == ST_IDLE);
        n.status.tx_free_flag = tx_space;
        n.status.rx_valid_flag = !rx_empty;
        if (i_rx_read) begin
            n.status.rx_overrun_flag = 1'b0;
        end
        if (overrun_now) begin
            n.status.rx_overrun_flag = 1'b1;
            n.ovf_pending = 1'b1;
        end

        // DMA error holds off until the receive FIFO has emptied; buffer
        // completion alone says nothing about what is left in the FIFO
        if (i_dma.rx_dma_reset) begin
            n.dma_err = 2'h0;
        end
        n.dma_err = n.dma_err & ~i_dma.rx_dma_load;
        if (r.ovf_pending && rx_empty && !overrun_now) begin
            n.ovf_pending = 1'b0;
            if (i_dma.rx_dma_active[0]) begin
                n.dma_err[0] = 1'b1;
            end else if (i_dma.rx_dma_active[1]) begin
                n.dma_err[1] = 1'b1;
            end
        end

        // Events, one-cycle pulses
        n.ev.tx_idle = n.status.tx_idle_flag && !r.status.tx_idle_flag;
        n.ev.tx_free = n.status.tx_free_flag && !r.status.tx_free_flag;
        n.ev.rx_valid = n.status.rx_valid_flag && !r.status.rx_valid_flag;
        n.dma_prev = {i_dma.tx_dma_active, i_dma.rx_dma_active};
        n.ev.tx_dma_done = r.dma_prev[3:2] & ~i_dma.tx_dma_active;
        n.ev.rx_dma_done = r.dma_prev[1:0] & ~i_dma.rx_dma_active;
        n.ev.rx_overrun_irq = overrun_now;

        // Pending flags: a new event wins over a clear in the same cycle
        n.irq_flags = (r.irq_flags & ~i_irq_clear) | n.ev;
        n.irq = |(n.irq_flags & i_irq_mask) && i_top_irq_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= RESET_STATE;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign o_status = r.status;
    assign o_event = r.ev;
    assign o_irq_flags = r.irq_flags;
    assign o_irq = r.irq;
    assign o_rx_dma_error = r.dma_err;
    assign o_sclk = r.sclk;
    assign o_sclk_oe = r.sclk_oe;
    assign o_mosi = r.mosi;
    assign o_mosi_oe = r.mosi_oe;

endmodule : spi_master_fifo_controller
`default_nettype wire

// ### bench/spi_slave_model.sv
// Behavioural serial slave that answers the master on its data return line
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_sclk_oe,
    input wire logic i_mosi,
    input wire spi_master_pkg::spi_config_s i_config,
    output logic o_miso,
    output logic o_done,
    output logic [7:0] o_got,
    output logic [7:0] o_sent
);
    import spi_master_pkg::*;
    logic [7:0] reply;
    logic [7:0] shin;
    logic [2:0] d;
    logic [2:0] n;
    logic mreg, sclk_prev, oe_d, pol_d, pol_dd, fin, quiet, lead, pha;
    function automatic logic [2:0] idx(input logic [2:0] k);
        return i_config.bit_order_bit ? k : 3'h7 - k;
    endfunction : idx
    // Clock level moves when polarity or enable changes; those steps are not data edges
    assign quiet = !i_sclk_oe || !oe_d || i_config.clock_polarity_bit != pol_d || pol_d != pol_dd;
    assign pha = i_config.clock_phase_bit;
    assign lead = sclk_prev == i_config.clock_polarity_bit;
    assign o_miso = pha ? mreg : reply[idx(d)];
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reply <= 8'h3c;
            {d, n, mreg, sclk_prev, oe_d, pol_d, pol_dd, fin, o_done} <= 13'h0;
        end else begin
            sclk_prev <= i_sclk;
            oe_d <= i_sclk_oe;
            pol_d <= i_config.clock_polarity_bit;
            pol_dd <= pol_d;
            o_done <= fin;
            fin <= 1'b0;
            if (fin) begin
                o_got <= shin;
                o_sent <= reply;
                reply <= reply + 8'h47;
                // Released line shows the inverse, never a stale bit
                if (pha) mreg <= ~mreg;
            end
            if (quiet) begin
                d <= 3'h0;
                n <= 3'h0;
            end else if (i_sclk != sclk_prev) begin
                if (lead != pha) begin
                    shin[idx(n)] <= i_mosi;
                    n <= n + 3'h1;
                    fin <= n == 3'h7;
                end else begin
                    if (pha) mreg <= reply[idx(d)];
                    d <= d + 3'h1;
                end
            end
        end
    end
endmodule : spi_slave_model
`default_nettype wire

// ### bench/spi_master_fifo_controller_monitor.sv
// Port checker of the serial master, bound to the controller
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_map.svh"
module spi_master_fifo_controller_monitor
    import spi_master_pkg::*;
#(
    parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire spi_master_pkg::spi_config_s i_config,
    input wire logic i_tx_write,
    input wire spi_master_pkg::dma_in_s i_dma,
    input wire logic [`SPI_EVT_W-1:0] i_irq_mask,
    input wire logic i_top_irq_mask,
    input wire spi_master_pkg::spi_status_s o_status,
    input wire spi_master_pkg::spi_event_s o_event,
    input wire logic [`SPI_EVT_W-1:0] o_irq_flags,
    input wire logic o_irq,
    input wire logic [1:0] o_rx_dma_error,
    input wire logic o_sclk,
    input wire logic o_sclk_oe,
    input wire logic o_mosi_oe
);
    logic en, sclk_d_reg;
    logic [`SPI_DIV_W-1:0] half;
    logic [`SPI_DIV_W-1:0] gap_reg;
    assign en = i_config.controller_mode_field == `SPI_MODE_SPI && i_config.spi_master_select;
    assign half = `SPI_DIV_W'(i_config.rate_linear + 5'h1) << i_config.rate_exponent;
    // Cycles since the last clock edge; saturates so long idle gaps never wrap
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_reg <= '1;
            sclk_d_reg <= 1'b0;
        end else begin
            gap_reg <= (o_sclk != sclk_d_reg) ? `SPI_DIV_W'(1) : gap_reg + `SPI_DIV_W'(gap_reg != '1);
            sclk_d_reg <= o_sclk;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    a_oe_follows_mode: assert property (
        $past(i_reset_n) |-> {o_sclk_oe, o_mosi_oe} == {2{$past(en)}})
        else $error("enable outputs do not follow mode");
    a_sclk_idle_level: assert property (
        o_status.tx_idle_flag && $past(o_status.tx_idle_flag) && o_sclk_oe && $past(o_sclk_oe)
        && $stable(i_config) |-> o_sclk == i_config.clock_polarity_bit)
        else $error("clock not at idle level");
    a_write_clears_idle: assert property (
        i_tx_write && o_status.tx_idle_flag |=> !o_status.tx_idle_flag)
        else $error("idle flag stayed after write");
    a_full_not_idle: assert property (!o_status.tx_free_flag |-> !o_status.tx_idle_flag)
        else $error("full and idle together");
    a_overrun_when_full: assert property (
        o_event.rx_overrun_irq |-> o_status.rx_overrun_flag && o_status.rx_valid_flag)
        else $error("overrun without full receive side");
    a_irq_both_masks: assert property (
        $past(i_reset_n) |-> o_irq == ((|(o_irq_flags & $past(i_irq_mask))) && $past(i_top_irq_mask)))
        else $error("interrupt line disagrees with masks");
    a_event_sets_pending: assert property ((o_irq_flags & o_event) == o_event)
        else $error("event without pending flag");
    a_bit_half_period: assert property (
        $changed(o_sclk) && o_sclk_oe && $past(o_sclk_oe) && $stable(i_config) |-> gap_reg >= half)
        else $error("clock edges too close");
    a_dma_err_drained: assert property ($rose(o_rx_dma_error[0]) |-> !o_status.rx_valid_flag)
        else $error("dma error before drain");
    a_dma_err_clear: assert property (
        $fell(o_rx_dma_error[0]) |-> $past(i_dma.rx_dma_reset) || $past(i_dma.rx_dma_load[0]))
        else $error("dma error cleared without cause");
    c_overrun: cover property (o_event.rx_overrun_irq);
    c_underrun: cover property (o_event.tx_underrun_irq);
    c_dma_error: cover property ($rose(o_rx_dma_error[0]));
endmodule : spi_master_fifo_controller_monitor
bind spi_master_fifo_controller spi_master_fifo_controller_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) monitor_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_config(i_config), .i_tx_write(i_tx_write), .i_dma(i_dma),
    .i_irq_mask(i_irq_mask), .i_top_irq_mask(i_top_irq_mask), .o_status(o_status), .o_event(o_event),
    .o_irq_flags(o_irq_flags), .o_irq(o_irq), .o_rx_dma_error(o_rx_dma_error), .o_sclk(o_sclk),
    .o_sclk_oe(o_sclk_oe), .o_mosi_oe(o_mosi_oe));
`default_nettype wire

// ### bench/tb_spi_master_fifo_controller.sv
// Self-checking bench: slave model plus reference queues for both directions
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_map.svh"
module tb_spi_master_fifo_controller;
    import spi_master_pkg::*;
    logic clk, rst_n, wr_en, rd_en, top, miso, irq, sclk, sclk_oe, mosi, done;
    logic [7:0] wdata, rx_data, got, sent, last_tx, auto_exp;
    logic [8:0] mask, clr, flags;
    logic [1:0] dma_err;
    logic [31:0] seed = 32'd46616;
    spi_config_s cfg;
    dma_in_s dma;
    spi_status_s status;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    int err_total, n_compared, cycles;
    spi_master_fifo_controller #(.FIFO_DEPTH(`SPI_FIFO_DEPTH)) spi_master_fifo_controller_inst (
        .i_clock(clk), .i_reset_n(rst_n), .i_config(cfg), .i_tx_write(wr_en), .i_tx_data(wdata), .i_rx_read(rd_en),
        .i_dma(dma), .i_irq_mask(mask), .i_top_irq_mask(top), .i_irq_clear(clr), .i_miso(miso), .o_rx_data(rx_data),
        .o_status(status), .o_event(), .o_irq_flags(flags), .o_irq(irq), .o_rx_dma_error(dma_err), .o_sclk(sclk),
        .o_sclk_oe(sclk_oe), .o_mosi(mosi), .o_mosi_oe());
    spi_slave_model spi_slave_model_inst (.i_clock(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_sclk_oe(sclk_oe),
        .i_mosi(mosi), .i_config(cfg), .o_miso(miso), .o_done(done), .o_got(got), .o_sent(sent));
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc
    // Four characters fit at once, counting the one in the shifter
    task automatic wr(input int k);
        for (int i = 0; i < k; i++) begin
            wr_en = 1'b1;
            wdata = rnd();
            if (tx_q.size() < `SPI_FIFO_DEPTH) last_tx = wdata;
            if (tx_q.size() < `SPI_FIFO_DEPTH) tx_q.push_back(wdata);
            cyc(1);
        end
        wr_en = 1'b0;
    endtask : wr
    task automatic idle();
        cyc(3);
        for (int i = 0; i < 5000 && status.tx_idle_flag !== 1'b1; i++) cyc(1);
        cyc(20);
    endtask : idle
    task automatic drain();
        while (rx_q.size()) begin
            rd_en = 1'b1;
            cyc(1);
            rd_en = 1'b0;
            cyc(1);
            chk("rx data", rx_data, rx_q.pop_front());
        end
        chk("rx valid", status.rx_valid_flag, 1'b0);
    endtask : drain
    // Mode goes to zero first so a polarity change never leaves a stray character; pending flags start clean
    task automatic setc(input logic pol, pha, ord, rpt);
        cfg.controller_mode_field = 2'h0;
        clr = 9'h1ff;
        cyc(2);
        clr = '0;
        cfg = '{2'h2, 1'b1, pol, pha, ord, 1'b0, rpt, 4'h3, 4'(rnd() & 8'h01)};
        cyc(3);
    endtask : setc
    ////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (done) begin
            chk("mosi byte", got, tx_q.size() ? tx_q.pop_front() : auto_exp);
            if (rx_q.size() < `SPI_FIFO_DEPTH) rx_q.push_back(sent);
        end
        if (cycles == 40000) begin
            err_total++;
            results();
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_n, wr_en, rd_en, top, wdata, last_tx, cfg, dma, mask, clr} = '0;
        auto_exp = 8'hxx;
        {err_total, n_compared, cycles} = '0;
        cyc(8);
        rst_n = 1'b1;
        chk("reset status", status, `SPI_STATUS_RESET);
        for (int m = 0; m < 8; m++) begin
            setc(m[0], m[1], m[2], 1'b0);
            wr(2);
            idle();
            drain();
        end
        dma.rx_dma_active = 2'b01;
        wr(6);
        chk("free when full", status.tx_free_flag, 1'b0);
        idle();
        wr(1);
        idle();
        chk("overrun flag", status.rx_overrun_flag, 1'b1);
        chk("dma error held", dma_err, 2'b00);
        drain();
        cyc(2);
        chk("dma error", dma_err, 2'b01);
        dma.rx_dma_reset = 1'b1;
        cyc(1);
        dma = '0;
        cyc(1);
        chk("dma error reset", dma_err, 2'b00);
        dma.tx_dma_active = 2'b11;
        cyc(2);
        dma = '0;
        cyc(2);
        chk("dma done pending", flags[7:3], 5'b10111);
        mask = 9'h1ff;
        cyc(2);
        chk("irq top masked", irq, 1'b0);
        top = 1'b1;
        cyc(2);
        chk("irq enabled", irq, 1'b1);
        clr = 9'h1ff;
        cyc(1);
        clr = '0;
        cyc(1);
        chk("pending cleared", flags, 9'h000);
        for (int r = 0; r < 2; r++) begin
            setc(1'b0, 1'b0, 1'b0, r[0]);
            wr(1);
            idle();
            auto_exp = r[0] ? last_tx : `SPI_BUSY_TOKEN;
            cfg.auto_tx_enable = 1'b1;
            cyc(100);
            for (int i = 0; i < 1000 && status.tx_idle_flag !== 1'b1; i++) cyc(1);
            cfg.auto_tx_enable = 1'b0;
            idle();
            chk("underrun pending", flags[8], 1'b1);
            drain();
            cyc(200);
            chk("no reception", status.rx_valid_flag, 1'b0);
            auto_exp = 8'hxx;
        end
        setc(1'b1, 1'b0, 1'b0, 1'b0);
        wr(1);
        idle();
        cfg.clock_polarity_bit = 1'b0;
        cyc(4);
        tx_q.push_back(`SPI_EXTRA_TOKEN);
        wr(1);
        idle();
        drain();
        results();
    end
endmodule : tb_spi_master_fifo_controller
`default_nettype wire
